//--- design/stop_exit_clock_switch.sv
// stop-mode exit clock source control and address-latch strobe quieting
// Function
// - ring oscillator used on stop exit only when the select bit is one
// - with ring selected, execution resumes within 100 ns of wake
// - after 65536 crystal edges switch to crystal, clear ring flag
// - crystal oscillator held off through all of stop mode
// - select bit resets to zero; exit then waits for the crystal
// - quiet bit set holds the latch strobe static for on-chip accesses
// - quiet bit set still toggles the strobe for off-chip accesses
// - quiet bit resets to zero; strobe then toggles at crystal/4
// - writing one to the stop bit in ST_RUN enters stop mode after that cycle
module stop_exit_clock_switch
    import clkctl_pkg::*;
#(
    parameter int CRYSTAL_CLOCK_INPUT_COUNT = CRYSTAL_CLOCK_INPUT_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [clkctl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [clkctl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [clkctl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic crystal_clock_input,
    input wire logic wake_irq,
    input wire logic offchip_access,
    output logic crystal_osc_enable,
    output logic ring_select,
    output logic core_run,
    output logic ring_clock_active_flag,
    output logic latch_strobe
);
    import clkctl_pkg::*;

    localparam int CNT_W = $clog2(CRYSTAL_CLOCK_INPUT_COUNT + 1);
    localparam int resume_lim = RESUME_CYC;

    ////////////////////////////////////////////////////////////////////
    // address match, shared by read and write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    mode_e state_r;
    mode_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic sel_r;
    logic quiet_r;
    logic ring_flag_r;
    logic ring_flag_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic wake_s1;
    logic wake_s2;
    logic crystal_clock_input_s1;
    logic crystal_clock_input_s2;
    logic crystal_clock_input_s3;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            crystal_clock_input_s1 <= 1'b0;
            crystal_clock_input_s2 <= 1'b0;
            crystal_clock_input_s3 <= 1'b0;
        end else begin
            wake_s1 <= wake_irq;
            wake_s2 <= wake_s1;
            crystal_clock_input_s1 <= crystal_clock_input;
            crystal_clock_input_s2 <= crystal_clock_input_s1;
            crystal_clock_input_s3 <= crystal_clock_input_s2;
        end
    end

    wire crystal_clock_input_rise = crystal_clock_input_s2 && !crystal_clock_input_s3;

    ////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_ext = reg_wr && hit(reg_addr, EXT_FLAGS_OFS);
    wire wr_pmr = reg_wr && hit(reg_addr, PMR_OFS);
    wire wr_power_control_reg = reg_wr && hit(reg_addr, POWER_CONTROL_REG_OFS);
    wire stop_req = wr_power_control_reg && reg_wdata[STOP_BIT] && (state_r == ST_RUN);
    wire in_stop = (state_r == ST_STOP);
    wire waiting = (state_r == ST_RING) || (state_r == ST_XWAIT);
    wire count_done = waiting && crystal_clock_input_rise &&
                      (cnt_r == CNT_W'(CRYSTAL_CLOCK_INPUT_COUNT - 1));

    logic [DATA_W-1:0] ext_rd;
    logic [DATA_W-1:0] pmr_rd;
    logic [DATA_W-1:0] power_control_reg_rd;
    always_comb begin
        ext_rd = RESET_BYTE;
        ext_rd[SEL_BIT] = sel_r;
        ext_rd[RING_BIT] = ring_flag_r;
        pmr_rd = RESET_BYTE;
        pmr_rd[QUIET_BIT] = quiet_r;
        power_control_reg_rd = RESET_BYTE;
        power_control_reg_rd[STOP_BIT] = (state_r != ST_RUN);
    end

    always_comb begin
        rdata_nxt = RESET_BYTE;
        if (reg_rd) begin
            if (hit(reg_addr, EXT_FLAGS_OFS)) begin
                rdata_nxt = ext_rd;
            end else if (hit(reg_addr, PMR_OFS)) begin
                rdata_nxt = pmr_rd;
            end else if (hit(reg_addr, POWER_CONTROL_REG_OFS)) begin
                rdata_nxt = power_control_reg_rd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // exit mode state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (stop_req) begin
                    state_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                if (wake_s2) begin
                    state_nxt = sel_r ? ST_RING : ST_XWAIT;
                end
            end
            ST_RING, ST_XWAIT: begin
                if (count_done) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (!waiting) begin
            cnt_nxt = '0;
        end else if (crystal_clock_input_rise) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_comb begin
        ring_flag_nxt = ring_flag_r;
        if (in_stop && wake_s2 && sel_r) begin
            ring_flag_nxt = 1'b1;
        end else if (count_done) begin
            ring_flag_nxt = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_RUN;
            cnt_r <= '0;
            ring_flag_r <= 1'b0;
            rdata_r <= RESET_BYTE;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ring_flag_r <= ring_flag_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // control bits, both clear at reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_r <= 1'b0;
            quiet_r <= 1'b0;
        end else begin
            if (wr_ext) begin
                sel_r <= reg_wdata[SEL_BIT];
            end
            if (wr_pmr) begin
                quiet_r <= reg_wdata[QUIET_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = rdata_r;
    assign crystal_osc_enable = !in_stop;
    assign ring_select = (state_r == ST_RING);
    assign core_run = (state_r == ST_RUN) || (state_r == ST_RING);
    assign ring_clock_active_flag = ring_flag_r;

    strobe_if sif ();
    assign sif.crystal_clock_input_rise = crystal_clock_input_rise;
    assign sif.quiet = quiet_r;
    assign sif.offchip = offchip_access;
    assign sif.run = core_run;
    assign latch_strobe = sif.strobe;

    latch_strobe_gen u_strobe (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sif(sif.gen)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    ring_needs_sel_a: assert property (
        $rose(ring_select) |-> $past(sel_r))
        else $error("ring clock used without select bit");
    fast_resume_a: assert property (
        ($rose(wake_s2) && in_stop && sel_r)
            |-> ##[1:resume_lim] (core_run && ring_select))
        else $error("ring resume too slow");
    switchover_count_a: assert property (
        $fell(ring_clock_active_flag)
            |-> ($past(cnt_r) == CNT_W'(CRYSTAL_CLOCK_INPUT_COUNT - 1))
                && !ring_select && core_run)
        else $error("switchover at wrong crystal count");
    osc_off_stop_a: assert property (
        in_stop |-> (!crystal_osc_enable && !core_run))
        else $error("crystal running during stop");
    crystal_wait_a: assert property (
        (in_stop && wake_s2 && !sel_r)
            |=> (state_r == ST_XWAIT) && !core_run && !ring_clock_active_flag)
        else $error("exit did not wait for crystal");
    reset_clear_a: assert property (
        $past(sys_rst) |-> (!sel_r && !quiet_r))
        else $error("control bits not clear after reset");
    stop_entry_a: assert property (
        stop_req |=> in_stop ##0 !core_run)
        else $error("stop request not taken");
    flag_holds_a: assert property (
        ring_select |-> ring_clock_active_flag)
        else $error("ring flag low while on ring clock");
    no_flag_early_a: assert property (
        (ring_clock_active_flag && !count_done) |=> ring_clock_active_flag)
        else $error("ring flag cleared before switchover");

    // register side and exit sequencing
    sel_write_a: assert property (
        (wr_ext && reg_wdata[SEL_BIT]) |=> sel_r)
        else $error("select bit not set by write");
    sel_clear_a: assert property (
        (wr_ext && !reg_wdata[SEL_BIT]) |=> !sel_r)
        else $error("select bit not cleared by write");
    ring_core_run_a: assert property (
        ring_select |-> core_run)
        else $error("core halted while on ring clock");
    exit_needs_wake_a: assert property (
        $fell(in_stop) |-> $past(wake_s2))
        else $error("stop left without a wake request");
    switch_to_run_a: assert property (
        count_done
            |=> ((state_r == ST_RUN) && !ring_select && core_run))
        else $error("no switchover after final crystal edge");
    count_restart_a: assert property (
        !waiting |=> (cnt_r == '0))
        else $error("crystal count not restarted");
    xwait_plain_a: assert property (
        (state_r == ST_XWAIT)
            |-> (!ring_select && !ring_clock_active_flag))
        else $error("ring clock used while waiting for crystal");
    quiet_write_a: assert property (
        (wr_pmr && reg_wdata[QUIET_BIT]) |=> quiet_r)
        else $error("quiet bit not set by write");
    quiet_clear_a: assert property (
        (wr_pmr && !reg_wdata[QUIET_BIT]) |=> !quiet_r)
        else $error("quiet bit not cleared by write");
    run_holds_a: assert property (
        ((state_r == ST_RUN) && !stop_req)
            |=> (state_r == ST_RUN))
        else $error("run left without a stop request");
    flag_rise_a: assert property (
        $rose(ring_clock_active_flag)
            |-> ($past(in_stop) && $past(wake_s2) && $past(sel_r)))
        else $error("ring flag set outside a ring-clock resume");

    ring_exit_c: cover property ($fell(ring_clock_active_flag));
    crystal_exit_c: cover property (
        (state_r == ST_XWAIT) ##1 (state_r == ST_RUN));
    quiet_offchip_c: cover property (
        quiet_r && offchip_access && $changed(latch_strobe));
    stop_entry_c: cover property (stop_req);
    quiet_static_c: cover property (
        quiet_r && core_run && !offchip_access);
endmodule // stop_exit_clock_switch

//--- design/clkctl_pkg.sv
// constants and types shared by the stop-exit clock switch block
package clkctl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] EXT_FLAGS_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] PMR_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] POWER_CONTROL_REG_OFS = 4'h8;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam int SEL_BIT = 1;
    localparam int RING_BIT = 2;
    localparam int QUIET_BIT = 2;
    localparam int STOP_BIT = 1;
    localparam int CRYSTAL_CLOCK_INPUT_CYCLES = 65536;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RESUME_NS = 100;
    localparam int RESUME_CYC = RESUME_NS * 1000 / CLK_PERIOD_PS;
    localparam int STROBE_HALF = 2;
    typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_RING, ST_XWAIT} mode_e;
endpackage

//--- design/strobe_if.sv
// carrier between the clock switch and the latch strobe generator
interface strobe_if;
    logic crystal_clock_input_rise;
    logic quiet;
    logic offchip;
    logic run;
    logic strobe;
    modport ctrl (output crystal_clock_input_rise, output quiet, output offchip,
                  output run, input strobe);
    modport gen (input crystal_clock_input_rise, input quiet, input offchip,
                 input run, output strobe);
endinterface

//--- design/latch_strobe_gen.sv
// address-latch strobe generator, one toggle per two crystal edges
module latch_strobe_gen
    import clkctl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    strobe_if.gen sif
);
    logic strobe_r;
    logic [1:0] half_r;
    wire active = sif.run && (!sif.quiet || sif.offchip);
    wire half_done = (half_r == 2'(STROBE_HALF - 1));

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            half_r <= '0;
            strobe_r <= 1'b0;
        end else if (!active) begin
            // static while quiet and on-chip
            half_r <= '0;
            strobe_r <= 1'b0;
        end else if (sif.crystal_clock_input_rise) begin
            // period of four crystal clocks
            half_r <= half_done ? 2'b00 : half_r + 2'b01;
            if (half_done) begin
                strobe_r <= ~strobe_r;
            end
        end
    end

    assign sif.strobe = strobe_r;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    quiet_static_a: assert property (
        (sif.run && sif.quiet && !sif.offchip) |=> !sif.strobe)
        else $error("strobe moved during on-chip access while quiet");
    toggle_on_edge_a: assert property (
        ($changed(sif.strobe) && $past(active)) |-> $past(sif.crystal_clock_input_rise))
        else $error("strobe toggled without a crystal edge");
    offchip_toggle_a: assert property (
        (active && sif.crystal_clock_input_rise && half_done) |=> $changed(sif.strobe))
        else $error("strobe missed its toggle");
endmodule // latch_strobe_gen

//--- test/stop_exit_clock_switch_tb.sv
// self-checking bench for the stop-exit clock switch
module stop_exit_clock_switch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clkctl_pkg::*;
    localparam int XN = 8;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic crystal_clock_input = 1'b0;
    logic wake_irq = 1'b0;
    logic offchip_access = 1'b0;
    logic crystal_osc_enable;
    logic ring_select;
    logic core_run;
    logic ring_clock_active_flag;
    logic latch_strobe;
    int xdiv = 0;
    int xrises = 0;
    int cyc = 0;
    int fails = 0;
    int n_tests = 0;
    logic [DATA_W-1:0] rd_val;
    // register model kept from the rules, read expectations queued
    int sel_m = 0;
    int quiet_m = 0;
    int ring_m = 0;
    int held_m = 0;
    logic [DATA_W-1:0] exp_q[$];

    stop_exit_clock_switch #(.CRYSTAL_CLOCK_INPUT_COUNT(XN)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .crystal_clock_input(crystal_clock_input),
        .wake_irq(wake_irq), .offchip_access(offchip_access),
        .crystal_osc_enable(crystal_osc_enable), .ring_select(ring_select),
        .core_run(core_run), .ring_clock_active_flag(ring_clock_active_flag),
        .latch_strobe(latch_strobe));

    always #4 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    // crystal pin, eight system cycles per period, silent while stopped
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        xdiv <= (xdiv + 1) % 8;
        crystal_clock_input <= crystal_osc_enable && xdiv >= 4;
        if (crystal_osc_enable && xdiv >= 4 && !crystal_clock_input) begin
            xrises <= xrises + 1;
        end
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check_reg(string name, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_pin(string name, logic exp, logic got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask

    function automatic logic [DATA_W-1:0] model_rd(logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = RESET_BYTE;
        if (a == EXT_FLAGS_OFS) begin
            v[SEL_BIT] = sel_m[0];
            v[RING_BIT] = ring_m[0];
        end else if (a == PMR_OFS) begin
            v[QUIET_BIT] = quiet_m[0];
        end else if (a == POWER_CONTROL_REG_OFS) begin
            v[STOP_BIT] = held_m[0];
        end
        return v;
    endfunction

    task automatic reg_write(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        if (a == EXT_FLAGS_OFS) sel_m = d[SEL_BIT];
        if (a == PMR_OFS) quiet_m = d[QUIET_BIT];
        if (a == POWER_CONTROL_REG_OFS && d[STOP_BIT]) held_m = 1;
    endtask

    task automatic reg_read(logic [ADDR_W-1:0] a, output logic [7:0] d);
        exp_q.push_back(model_rd(a));
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // stop, wake, then follow the exit to the crystal switchover
    task automatic stop_exit(int sel);
        int x0;
        logic [7:0] d;
        d = 8'($urandom()) & 8'hF9 | 8'(sel << SEL_BIT);
        reg_write(EXT_FLAGS_OFS, d);
        reg_read(EXT_FLAGS_OFS, rd_val);
        check_reg("ext_sel", exp_q.pop_front(), rd_val);
        reg_write(POWER_CONTROL_REG_OFS, 8'h02);
        @(negedge sys_clk);
        check_pin("osc_stop", 1'b0, crystal_osc_enable);
        check_pin("run_stop", 1'b0, core_run);
        reg_read(POWER_CONTROL_REG_OFS, rd_val);
        check_reg("power_control_reg_stop", exp_q.pop_front(), rd_val);
        x0 = xrises;
        repeat (16 + $urandom_range(0, 9)) @(posedge sys_clk);
        check_pin("osc_held", 1'b0, crystal_osc_enable);
        wake_irq <= 1'b1;
        repeat (RESUME_CYC) @(posedge sys_clk);
        wake_irq <= 1'b0;
        ring_m = sel;
        @(negedge sys_clk);
        check_pin("ring_sel", sel[0], ring_select);
        check_pin("run_wake", sel[0], core_run);
        check_pin("flag_set", ring_m[0], ring_clock_active_flag);
        reg_write(EXT_FLAGS_OFS, 8'(sel << SEL_BIT));
        reg_read(EXT_FLAGS_OFS, rd_val);
        check_reg("ext_ring", exp_q.pop_front(), rd_val);
        // no network, serial or timed work while on ring
        for (int i = 0; i < 300 && xrises < x0 + XN - 1; i++) begin
            @(posedge sys_clk);
        end
        @(negedge sys_clk);
        check_pin("flag_hold", ring_m[0], ring_clock_active_flag);
        check_pin("run_hold", sel[0], core_run);
        for (int i = 0; i < 300 && xrises < x0 + XN; i++) begin
            @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        check_pin("ring_off", 1'b0, ring_select);
        check_pin("flag_clr", 1'b0, ring_clock_active_flag);
        check_pin("run_crystal_clock_input", 1'b1, core_run);
        ring_m = 0;
        held_m = 0;
        reg_read(POWER_CONTROL_REG_OFS, rd_val);
        check_reg("power_control_reg_run", exp_q.pop_front(), rd_val);
    endtask

    task automatic count_toggles(output int n);
        logic prev;
        n = 0;
        @(negedge sys_clk);
        prev = latch_strobe;
        repeat (128) begin
            @(negedge sys_clk);
            if (latch_strobe !== prev) n++;
            prev = latch_strobe;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        void'($urandom(57));
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check_pin("osc_rst", 1'b1, crystal_osc_enable);
        check_pin("ring_rst", 1'b0, ring_select);
        check_pin("flag_rst", 1'b0, ring_clock_active_flag);
        reg_read(EXT_FLAGS_OFS, rd_val);
        check_reg("ext_rst", exp_q.pop_front(), rd_val);
        reg_read(PMR_OFS, rd_val);
        check_reg("pmr_rst", exp_q.pop_front(), rd_val);
        reg_read(4'hC, rd_val);
        check_reg("unmapped", exp_q.pop_front(), rd_val);
        stop_exit(1);
        stop_exit(0);
        // quiet bit and off-chip level against toggles in 16 crystal periods
        for (int k = 0; k < 3; k++) begin
            reg_write(PMR_OFS,
                      8'($urandom()) & 8'hFB | 8'((k > 0) << QUIET_BIT));
            offchip_access <= (k == 0) ? 1'($urandom()) : (k == 2);
            reg_read(PMR_OFS, rd_val);
            check_reg("pmr_rw", exp_q.pop_front(), rd_val);
            repeat (48) @(posedge sys_clk);
            count_toggles(n);
            check_reg("strobe", (k == 1) ? 8'h00 : 8'h08, 8'(n));
        end
        report_and_stop();
    end
endmodule // stop_exit_clock_switch_tb
